// file: pkg/ssdt_defines.vh
// constants shared by the safety diagnostics self-test block
`ifndef SSDT_DEFINES_VH
`define SSDT_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define SSDT_CLK_MHZ 200
`define SSDT_ALIVE_PERIOD_US 8192
`define SSDT_ALIVE_CYC (`SSDT_ALIVE_PERIOD_US * `SSDT_CLK_MHZ)
`define SSDT_LBIST_TIME_MS 30
`define SSDT_LBIST_CYC (`SSDT_LBIST_TIME_MS * 1000 * `SSDT_CLK_MHZ)
`define SSDT_XDCR_TIME_MS 52
`define SSDT_XDCR_CYC (`SSDT_XDCR_TIME_MS * 1000 * `SSDT_CLK_MHZ)
`define SSDT_WDG_WINDOW_US 10
`define SSDT_WDG_WINDOW_CYC (`SSDT_WDG_WINDOW_US * `SSDT_CLK_MHZ)

// ****************************************
// register byte offsets
// ****************************************
`define SSDT_OFF_CTRL 8'h00
`define SSDT_OFF_STAT 8'h04
`define SSDT_OFF_ERR 8'h08
`define SSDT_OFF_AUX 8'h0c
`define SSDT_OFF_SIG 8'h10

// ****************************************
// field positions
// ****************************************
`define SSDT_STAT_DONE 0
`define SSDT_STAT_LRUN 1
`define SSDT_STAT_XRUN 2
`define SSDT_ERR_FAIL 0
`define SSDT_ERR_WWIN 1
`define SSDT_ERR_WPER 2
`define SSDT_NV_LPWR 19
`define SSDT_NV_XSE 18
`define SSDT_NV_DIS 13

// ****************************************
// special commands and seeds
// ****************************************
`define SSDT_CMD_LBIST 8'h01
`define SSDT_CMD_XDCR 8'h02
`define SSDT_CMD_BOTH 8'h03
`define SSDT_LFSR_SEED 31'h0000_0001
`define SSDT_MISR_SEED 31'h0000_0000

`endif

// file: rtl/ssdt_lbist.v
// logic self-test engine: stimulus generator, scan drive and signature compactor
`include "ssdt_defines.vh"

module ssdt_lbist #(
	parameter CHAINS = 31,
	parameter RUN_CYC = `SSDT_LBIST_CYC,
	parameter [30:0] GOLDEN = 31'h0000_0000
) (
	input wire sys_clk, // system clock
	input wire reset, // synchronous reset, high
	input wire start, // one-cycle start request
	output reg scan_enable, // chains shift while high
	output wire [CHAINS-1:0] scan_stim, // parallel chain inputs
	input wire [CHAINS-1:0] scan_resp, // parallel chain outputs
	output wire running, // test in progress
	output reg done_pulse, // one cycle at end of test
	output reg fail_pulse, // one cycle with done on mismatch
	output wire [CHAINS-1:0] signature // compacted result
);

	// ****************************************
	// state and storage
	// ****************************************
	localparam LB_IDLE = 2'b01;
	localparam LB_RUN = 2'b10;

	reg [1:0] state_ff;
	reg [31:0] cnt_ff;
	reg [CHAINS-1:0] lfsr_ff;
	reg [CHAINS-1:0] misr_ff;
	wire [CHAINS-1:0] nxt_misr;
	wire lfsr_fb;

	assign running = state_ff[1];
	assign scan_stim = lfsr_ff; // RL7
	assign signature = misr_ff;
	assign lfsr_fb = lfsr_ff[CHAINS-1] ^ lfsr_ff[CHAINS-4];

	// misr bit update, one per chain
	genvar gi;
	generate
		for (gi = 0; gi < CHAINS; gi = gi + 1) begin : g_misr
			if (gi == 0) begin : g_lsb
				assign nxt_misr[gi] = scan_resp[gi] ^ misr_ff[CHAINS-1] ^
					misr_ff[CHAINS-4]; // RL8
			end else begin : g_up
				assign nxt_misr[gi] = scan_resp[gi] ^ misr_ff[gi-1]; // RL8
			end
		end
	endgenerate

	// sequencer: seed, shift for the run time, then judge
	always @(posedge sys_clk) begin
		done_pulse <= 1'b0;
		fail_pulse <= 1'b0;
		if (reset) begin
			state_ff <= LB_IDLE;
			cnt_ff <= 32'h0000_0000;
			lfsr_ff <= `SSDT_LFSR_SEED;
			misr_ff <= `SSDT_MISR_SEED;
			scan_enable <= 1'b0;
		end else begin
			case (state_ff)
				LB_IDLE: begin
					if (start) begin
						state_ff <= LB_RUN;
						cnt_ff <= 32'h0000_0000;
						lfsr_ff <= `SSDT_LFSR_SEED;
						misr_ff <= `SSDT_MISR_SEED;
						scan_enable <= 1'b1; // RL6
					end
				end
				LB_RUN: begin
					lfsr_ff <= {lfsr_ff[CHAINS-2:0], lfsr_fb}; // RL7
					misr_ff <= nxt_misr; // RL8
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == RUN_CYC - 1) begin // RL9
						state_ff <= LB_IDLE;
						scan_enable <= 1'b0;
						done_pulse <= 1'b1;
						fail_pulse <= (nxt_misr != GOLDEN); // RL13
					end
				end
				default: begin
					state_ff <= LB_IDLE;
					scan_enable <= 1'b0;
				end
			endcase
		end
	end

endmodule // ssdt_lbist

// file: rtl/ssdt_top.v
// safety diagnostics: alive counter, oscillator watchdogs, self-tests, apb registers
//
// Added by the designer: register access over APB and the register offsets.
`include "ssdt_defines.vh"

// Functional notes
// RL1: 32-bit alive counter from zero, readable
// RL2: alive counter steps every 8.192 ms
// RL3: alive counter wraps, never saturates
// RL4: watchdogs always run, never gated
// RL5: cross-count oscillator periods against limits
// RL6: logic test drives 31 scan chains
// RL7: 31-bit lfsr feeds all chains
// RL8: misr compacts chain outputs to signature
// RL9: logic test lasts about 30 ms
// RL10: power-up logic test when nv bit 19
// RL11: both self-tests may run together
// RL12: logic done via done flag or running
// RL13: logic test failure sets fail flag
// RL14: transducer switched into test-current configuration
// RL15: rotate current, check angle, judge pass
// RL16: transducer test takes about 52 ms
// RL17: power-up transducer test when enable set
// RL18: special command starts transducer test
// RL19: transducer done via done flag or running
// RL20: host clears fail flag; failure sets it
// RL21: fail flag stays until host clears
// RL22: serial disable bit blocks command starts
// RL23: both power-up tests start in parallel
module ssdt_top #(
	parameter ALIVE_CYC = `SSDT_ALIVE_CYC,
	parameter LBIST_CYC = `SSDT_LBIST_CYC,
	parameter XDCR_CYC = `SSDT_XDCR_CYC,
	parameter [30:0] LBIST_GOLDEN = 31'h0000_0000,
	parameter [11:0] ANGLE_TOL = 12'h040,
	parameter [15:0] WIN_EDGES_LO = 16'h0004,
	parameter [15:0] WIN_EDGES_HI = 16'h0400,
	parameter [15:0] PER_MIN = 16'h0002,
	parameter [15:0] PER_MAX = 16'h0200
) (
	input wire sys_clk, // 200 mhz system clock
	input wire reset, // synchronous reset, high
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb write
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped
	input wire [23:0] nv_com_word, // nonvolatile common config word
	input wire ref_osc_clk, // second oscillator, sampled
	output wire scan_enable, // scan chains shift
	output wire [30:0] scan_stim, // scan chain inputs
	input wire [30:0] scan_resp, // scan chain outputs
	output reg xdcr_test_mode, // sensing element in test config
	output reg xdcr_current_dir, // test current direction
	output reg [2:0] xdcr_element_sel, // driven element group
	input wire [11:0] meas_angle, // measured angle
	input wire meas_valid, // measured angle strobe
	output reg selftest_fail_flag, // sticky self-test failure
	output wire wdg_fail // any watchdog failure flag
);

	// ****************************************
	// declarations
	// ****************************************
	localparam XS_IDLE = 2'b01;
	localparam XS_STEP = 2'b10;
	localparam [3:0] XDCR_LAST = 4'hf;
	localparam XDCR_DWELL = XDCR_CYC / 16;

	reg init_pend_ff, ref_d_ff, first_edge_ff, wdg_win_err_ff, wdg_per_err_ff;
	reg special_done_flag_ff, seen_ff, xdcr_bad_ff, xdcr_done_pulse, xdcr_fail_pulse;
	reg [1:0] xs_state_ff;
	reg [3:0] step_ff;
	reg [11:0] angle_ff;
	reg [15:0] win_cnt_ff, edge_cnt_ff, per_cnt_ff;
	reg [23:0] nv_com_ff;
	reg [31:0] alive_pre_ff, alive_count_field_ff, dwell_ff, nxt_prdata;
	wire ref_rise, win_end, wr_acc, rd_setup, cmd_wr, cmd_lbist, cmd_xdcr, err_wr, mapped;
	wire start_lbist, start_xdcr, lbist_running, lbist_done, lbist_fail, busy;
	wire step_end, step_bad, transducer_selftest_running_flag, logic_selftest_running_flag;
	wire [11:0] exp_angle;
	wire [30:0] lbist_sig;

	// ****************************************
	// helpers
	// ****************************************
	// address match against a register offset
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// distance between two angles on the circle
	function [11:0] angle_dist;
		input [11:0] a;
		input [11:0] b;
		reg [11:0] d;
		begin
			d = a - b;
			angle_dist = d[11] ? (12'h000 - d) : d;
		end
	endfunction

	// ****************************************
	// power-up configuration capture
	// ****************************************
	// nv word is caught on the first clock after reset release
	always @(posedge sys_clk) begin
		if (reset) begin
			init_pend_ff <= 1'b1;
			nv_com_ff <= 24'h00_0000;
		end else begin
			init_pend_ff <= 1'b0;
			if (init_pend_ff) begin
				nv_com_ff <= nv_com_word;
			end
		end
	end

	// ****************************************
	// alive counter
	// ****************************************
	// prescaler gives one step per alive period, count wraps freely
	always @(posedge sys_clk) begin
		if (reset) begin
			alive_pre_ff <= 32'h0000_0000;
			alive_count_field_ff <= 32'h0000_0000; // RL1
		end else if (alive_pre_ff == ALIVE_CYC - 1) begin // RL2
			alive_pre_ff <= 32'h0000_0000;
			alive_count_field_ff <= alive_count_field_ff + 32'h0000_0001; // RL3
		end else begin
			alive_pre_ff <= alive_pre_ff + 32'h0000_0001;
		end
	end

	// ****************************************
	// oscillator watchdogs
	// ****************************************
	assign ref_rise = ref_osc_clk & ~ref_d_ff;
	assign win_end = (win_cnt_ff == `SSDT_WDG_WINDOW_CYC - 1);
	assign err_wr = wr_acc & hit(paddr, `SSDT_OFF_ERR);

	// window counter of sys periods counts ref edges; no enable exists
	always @(posedge sys_clk) begin
		if (reset) begin
			ref_d_ff <= 1'b0;
			win_cnt_ff <= 16'h0000;
			edge_cnt_ff <= 16'h0000;
			per_cnt_ff <= 16'h0000;
			first_edge_ff <= 1'b1;
		end else begin
			ref_d_ff <= ref_osc_clk; // RL4
			win_cnt_ff <= win_end ? 16'h0000 : win_cnt_ff + 16'h0001;
			if (win_end) begin
				edge_cnt_ff <= {15'h0000, ref_rise};
			end else if (ref_rise && edge_cnt_ff != 16'hffff) begin
				edge_cnt_ff <= edge_cnt_ff + 16'h0001;
			end
			if (ref_rise) begin
				per_cnt_ff <= 16'h0000;
				first_edge_ff <= 1'b0;
			end else if (per_cnt_ff <= PER_MAX) begin
				per_cnt_ff <= per_cnt_ff + 16'h0001;
			end
		end
	end

	// sticky watchdog flags, set beats software clear
	always @(posedge sys_clk) begin
		if (reset) begin
			wdg_win_err_ff <= 1'b0;
			wdg_per_err_ff <= 1'b0;
		end else begin
			if (win_end && (edge_cnt_ff < WIN_EDGES_LO || edge_cnt_ff > WIN_EDGES_HI)) begin
				wdg_win_err_ff <= 1'b1; // RL5
			end else if (err_wr && pwdata[`SSDT_ERR_WWIN]) begin
				wdg_win_err_ff <= 1'b0;
			end
			if ((ref_rise && !first_edge_ff && per_cnt_ff < PER_MIN) ||
				(!ref_rise && per_cnt_ff == PER_MAX)) begin
				wdg_per_err_ff <= 1'b1; // RL5
			end else if (err_wr && pwdata[`SSDT_ERR_WPER]) begin
				wdg_per_err_ff <= 1'b0;
			end
		end
	end

	assign wdg_fail = wdg_win_err_ff | wdg_per_err_ff;

	// ****************************************
	// self-test start decode
	// ****************************************
	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign cmd_wr = wr_acc & hit(paddr, `SSDT_OFF_CTRL) & ~nv_com_ff[`SSDT_NV_DIS]; // RL22
	assign cmd_lbist = cmd_wr & (pwdata[7:0] == `SSDT_CMD_LBIST ||
		pwdata[7:0] == `SSDT_CMD_BOTH);
	assign cmd_xdcr = cmd_wr & (pwdata[7:0] == `SSDT_CMD_XDCR ||
		pwdata[7:0] == `SSDT_CMD_BOTH); // RL18
	// both power-up starts fire on the same cycle
	assign start_lbist = (init_pend_ff & nv_com_word[`SSDT_NV_LPWR]) | cmd_lbist; // RL10 RL23
	assign start_xdcr = (init_pend_ff & nv_com_word[`SSDT_NV_XSE]) | cmd_xdcr; // RL17 RL23

	// ****************************************
	// logic self-test engine
	// ****************************************
	// own sequencer, independent of the transducer test
	ssdt_lbist #(
		.CHAINS(31),
		.RUN_CYC(LBIST_CYC),
		.GOLDEN(LBIST_GOLDEN)
	) u_lbist (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(start_lbist & ~lbist_running), // RL11
		.scan_enable(scan_enable),
		.scan_stim(scan_stim),
		.scan_resp(scan_resp),
		.running(lbist_running),
		.done_pulse(lbist_done),
		.fail_pulse(lbist_fail),
		.signature(lbist_sig)
	);

	// ****************************************
	// transducer self-test sequencer
	// ****************************************
	// 16 positions: element group from low bits, current direction from top bit
	assign exp_angle = {step_ff, 8'h00};
	assign step_end = xs_state_ff[1] & (dwell_ff == XDCR_DWELL - 1);
	assign step_bad = ~seen_ff | (angle_dist(angle_ff, exp_angle) > ANGLE_TOL);

	always @(posedge sys_clk) begin
		xdcr_done_pulse <= 1'b0;
		xdcr_fail_pulse <= 1'b0;
		if (reset) begin
			xs_state_ff <= XS_IDLE;
			step_ff <= 4'h0;
			dwell_ff <= 32'h0000_0000;
			seen_ff <= 1'b0;
			angle_ff <= 12'h000;
			xdcr_bad_ff <= 1'b0;
			xdcr_test_mode <= 1'b0;
			xdcr_current_dir <= 1'b0;
			xdcr_element_sel <= 3'h0;
		end else begin
			case (xs_state_ff)
				XS_IDLE: begin
					if (start_xdcr) begin // RL11
						xs_state_ff <= XS_STEP;
						step_ff <= 4'h0;
						dwell_ff <= 32'h0000_0000;
						seen_ff <= 1'b0;
						xdcr_bad_ff <= 1'b0;
						xdcr_test_mode <= 1'b1; // RL14
						xdcr_current_dir <= 1'b0;
						xdcr_element_sel <= 3'h0;
					end
				end
				XS_STEP: begin
					dwell_ff <= step_end ? 32'h0000_0000 : dwell_ff + 32'h0000_0001;
					if (meas_valid) begin
						angle_ff <= meas_angle; // RL15
						seen_ff <= 1'b1;
					end
					if (step_end) begin
						seen_ff <= 1'b0;
						if (step_ff == XDCR_LAST) begin // RL16
							xs_state_ff <= XS_IDLE;
							xdcr_test_mode <= 1'b0;
							xdcr_done_pulse <= 1'b1;
							xdcr_fail_pulse <= xdcr_bad_ff | step_bad; // RL15
						end else begin
							xdcr_bad_ff <= xdcr_bad_ff | step_bad;
							step_ff <= step_ff + 4'h1;
							xdcr_element_sel <= step_ff[2:0] + 3'h1; // RL15
							xdcr_current_dir <= (step_ff == 4'h7) ? 1'b1 : xdcr_current_dir;
						end
					end
				end
				default: begin
					xs_state_ff <= XS_IDLE;
					xdcr_test_mode <= 1'b0;
				end
			endcase
		end
	end

	assign transducer_selftest_running_flag = xs_state_ff[1];
	assign logic_selftest_running_flag = lbist_running;
	assign busy = transducer_selftest_running_flag | logic_selftest_running_flag;

	// ****************************************
	// status and fail flags
	// ****************************************
	// done rises when a test ends with nothing else running, drops on a new start
	always @(posedge sys_clk) begin
		if (reset) begin
			special_done_flag_ff <= 1'b0;
		end else if (start_lbist | start_xdcr) begin
			special_done_flag_ff <= 1'b0;
		end else if ((lbist_done | xdcr_done_pulse) & ~busy) begin
			special_done_flag_ff <= 1'b1; // RL12 RL19
		end
	end

	// sticky failure, write one to clear, a failure in the same cycle wins
	always @(posedge sys_clk) begin
		if (reset) begin
			selftest_fail_flag <= 1'b0;
		end else if (lbist_fail | xdcr_fail_pulse) begin
			selftest_fail_flag <= 1'b1; // RL13 RL20
		end else if (err_wr && pwdata[`SSDT_ERR_FAIL]) begin
			selftest_fail_flag <= 1'b0; // RL21
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	// zero wait states: read data is captured in the setup phase
	assign pready = 1'b1;
	assign mapped = hit(paddr, `SSDT_OFF_CTRL) | hit(paddr, `SSDT_OFF_STAT) |
		hit(paddr, `SSDT_OFF_ERR) | hit(paddr, `SSDT_OFF_AUX) |
		hit(paddr, `SSDT_OFF_SIG);
	assign pslverr = psel & penable & ~mapped;

	// read mux
	always @* begin
		nxt_prdata = 32'h0000_0000;
		if (hit(paddr, `SSDT_OFF_STAT)) begin
			nxt_prdata[`SSDT_STAT_DONE] = special_done_flag_ff; // RL12 RL19
			nxt_prdata[`SSDT_STAT_LRUN] = logic_selftest_running_flag; // RL12
			nxt_prdata[`SSDT_STAT_XRUN] = transducer_selftest_running_flag; // RL19
		end else if (hit(paddr, `SSDT_OFF_ERR)) begin
			nxt_prdata[`SSDT_ERR_FAIL] = selftest_fail_flag;
			nxt_prdata[`SSDT_ERR_WWIN] = wdg_win_err_ff;
			nxt_prdata[`SSDT_ERR_WPER] = wdg_per_err_ff;
		end else if (hit(paddr, `SSDT_OFF_AUX)) begin
			nxt_prdata = alive_count_field_ff; // RL1
		end else if (hit(paddr, `SSDT_OFF_SIG)) begin
			nxt_prdata = {1'b0, lbist_sig}; // RL8
		end
	end

	// registered read data
	always @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= nxt_prdata;
		end
	end

endmodule // ssdt_top

// file: tb/ssdt_monitor.sv
// concurrent checks on the ports of the safety diagnostics self-test block
`include "ssdt_defines.vh"

module ssdt_monitor #(
	parameter int LBIST_CYC = 64,
	parameter int XDCR_CYC = 320
) (
	input wire logic sys_clk, // system clock
	input wire logic reset, // synchronous reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [23:0] nv_com_word, // nonvolatile common word
	input wire logic scan_enable, // scan chains shift
	input wire logic [30:0] scan_stim, // scan chain inputs
	input wire logic xdcr_test_mode, // transducer test config
	input wire logic xdcr_current_dir, // test current direction
	input wire logic [2:0] xdcr_element_sel, // driven element group
	input wire logic selftest_fail_flag // sticky failure
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] scan_len_ff;
	logic [15:0] xdcr_len_ff;

	// ****************************************
	// phase length counters and checks
	// ****************************************
	// length of the current shift and transducer phases
	always_ff @(posedge sys_clk) begin
		scan_len_ff <= scan_enable ? scan_len_ff + 16'h0001 : 16'h0000;
		xdcr_len_ff <= xdcr_test_mode ? xdcr_len_ff + 16'h0001 : 16'h0000;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_ctrl_wr;
		psel && penable && pwrite && paddr == `SSDT_OFF_CTRL;
	endsequence
	sequence s_clr_wr;
		psel && penable && pwrite && paddr == `SSDT_OFF_ERR && pwdata[`SSDT_ERR_FAIL];
	endsequence

	a_scan_phase_len: assert property ($fell(scan_enable) |-> scan_len_ff == LBIST_CYC)
		else $error("logic test shift length wrong");
	a_xdcr_phase_len: assert property ($fell(xdcr_test_mode) |-> xdcr_len_ff == XDCR_CYC)
		else $error("transducer test length wrong");
	a_stim_nonzero: assert property (scan_enable |-> scan_stim != 31'h0000_0000)
		else $error("stimulus register stuck at zero");
	a_stim_moves: assert property (scan_enable && $past(scan_enable) |-> $changed(scan_stim))
		else $error("stimulus did not shift");
	a_dir_half_turn: assert property ($changed(xdcr_current_dir) && xdcr_test_mode
		|-> xdcr_element_sel == 3'h0)
		else $error("current direction changed mid group");
	a_elem_steps: assert property (xdcr_test_mode && $past(xdcr_test_mode) && $changed(xdcr_element_sel)
		|-> xdcr_element_sel == $past(xdcr_element_sel) + 3'h1)
		else $error("element group skipped");
	a_fail_sticky: assert property (selftest_fail_flag && !(psel && penable && pwrite
		&& paddr == `SSDT_OFF_ERR && pwdata[`SSDT_ERR_FAIL]) |=> selftest_fail_flag)
		else $error("fail flag dropped without clear");
	a_fail_clears: assert property (s_clr_wr ##0 (!scan_enable && !xdcr_test_mode
		&& !$past(scan_enable) && !$past(xdcr_test_mode)) |=> !selftest_fail_flag)
		else $error("fail flag not cleared");
	a_xdcr_cmd_start: assert property (s_ctrl_wr ##0 (pwdata[1] && !nv_com_word[`SSDT_NV_DIS]
		&& !xdcr_test_mode) |-> ##[1:3] xdcr_test_mode)
		else $error("transducer test did not start");
	a_cmd_refused: assert property (s_ctrl_wr ##0 (nv_com_word[`SSDT_NV_DIS] && !scan_enable
		&& !xdcr_test_mode) |=> (!scan_enable && !xdcr_test_mode) [*3])
		else $error("disabled self-test started");
endmodule // ssdt_monitor

bind ssdt_top ssdt_monitor #(.LBIST_CYC(LBIST_CYC), .XDCR_CYC(XDCR_CYC)) ssdt_monitor_i (
	.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .nv_com_word(nv_com_word), .scan_enable(scan_enable),
	.scan_stim(scan_stim), .xdcr_test_mode(xdcr_test_mode), .xdcr_current_dir(xdcr_current_dir),
	.xdcr_element_sel(xdcr_element_sel), .selftest_fail_flag(selftest_fail_flag));

// file: tb/ssdt_top_tb.sv
// self-checking testbench for the safety diagnostics self-test block
`include "ssdt_defines.vh"

module ssdt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ALIVE_N = 16;
	localparam int LBIST_N = 64;
	localparam int XDCR_N = 320;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [23:0] nv_com_word = 24'h00_0000;
	logic ref_osc_clk = 1'b0;
	logic ref_run = 1'b1;
	logic [1:0] ref_div = 2'h0;
	logic [30:0] scan_resp = 31'h0000_0000;
	logic [11:0] ang_off = 12'h000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire scan_enable;
	wire [30:0] scan_stim;
	wire xdcr_test_mode;
	wire xdcr_current_dir;
	wire [2:0] xdcr_element_sel;
	wire [11:0] meas_angle;
	wire meas_valid;
	wire selftest_fail_flag;
	wire wdg_fail;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic er;

	// ****************************************
	// clock, oscillator and sensing element stand-in
	// ****************************************
	always #2.5 sys_clk = ~sys_clk;
	// second oscillator, period of eight system cycles while running
	always @(posedge sys_clk) begin
		ref_div <= ref_div + 2'h1;
		if (ref_run && ref_div == 2'h3) ref_osc_clk <= ~ref_osc_clk;
	end
	// ideal angle for the current step plus an injected error
	assign meas_angle = {xdcr_current_dir, xdcr_element_sel, 8'h00} + ang_off;
	assign meas_valid = xdcr_test_mode;

	ssdt_top #(.ALIVE_CYC(ALIVE_N), .LBIST_CYC(LBIST_N), .XDCR_CYC(XDCR_N)) ssdt_top_i (
		.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nv_com_word(nv_com_word), .ref_osc_clk(ref_osc_clk), .scan_enable(scan_enable),
		.scan_stim(scan_stim), .scan_resp(scan_resp), .xdcr_test_mode(xdcr_test_mode),
		.xdcr_current_dir(xdcr_current_dir), .xdcr_element_sel(xdcr_element_sel),
		.meas_angle(meas_angle), .meas_valid(meas_valid),
		.selftest_fail_flag(selftest_fail_flag), .wdg_fail(wdg_fail));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic [23:0] nv);
		@(posedge sys_clk);
		reset <= 1'b1;
		nv_com_word <= nv;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// poll status until the done flag shows
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			apb(1'b0, `SSDT_OFF_STAT, 32'h0000_0000);
			n++;
		end while (rd[`SSDT_STAT_DONE] !== 1'b1 && n < 400);
		chk(32'(rd[`SSDT_STAT_DONE]), 32'h0000_0001, "done seen");
	endtask

	task automatic t_alive;
		logic [31:0] a;
		apb(1'b0, `SSDT_OFF_AUX, 32'h0000_0000);
		a = rd;
		chk(a, 32'h0000_0000, "alive start");
		repeat (5 * ALIVE_N - 3) @(posedge sys_clk);
		apb(1'b0, `SSDT_OFF_AUX, 32'h0000_0000);
		chk(rd - a, 32'h0000_0005, "alive step");
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001, "unmapped error");
		chk(32'(pready), 32'h0000_0001, "ready high");
		$display("test alive done");
	endtask

	task automatic t_powerup;
		do_reset(24'h0C_0000);
		apb(1'b0, `SSDT_OFF_STAT, 32'h0000_0000);
		chk(rd & 32'h0000_0007, 32'h0000_0006, "both running");
		repeat (LBIST_N + 10) @(posedge sys_clk);
		apb(1'b0, `SSDT_OFF_STAT, 32'h0000_0000);
		chk(rd & 32'h0000_0007, 32'h0000_0004, "logic idle");
		wait_done;
		chk(rd & 32'h0000_0007, 32'h0000_0001, "all done");
		apb(1'b0, `SSDT_OFF_SIG, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "signature");
		chk(32'(selftest_fail_flag), 32'h0000_0000, "pass flag");
		apb(1'b1, `SSDT_OFF_CTRL, {24'h00_0000, `SSDT_CMD_BOTH});
		apb(1'b0, `SSDT_OFF_STAT, 32'h0000_0000);
		chk(rd & 32'h0000_0007, 32'h0000_0006, "both by command");
		wait_done;
		$display("test power-up done");
	endtask

	task automatic t_lbist_fail;
		scan_resp <= 31'h7FFF_FFFF;
		apb(1'b1, `SSDT_OFF_ERR, 32'h0000_0007);
		apb(1'b1, `SSDT_OFF_CTRL, {24'h00_0000, `SSDT_CMD_LBIST});
		repeat (3) @(posedge sys_clk);
		chk(32'(scan_enable), 32'h0000_0001, "shifting");
		wait_done;
		apb(1'b0, `SSDT_OFF_ERR, 32'h0000_0000);
		chk(rd & 32'h0000_0001, 32'h0000_0001, "logic fail");
		repeat (50) @(posedge sys_clk);
		chk(32'(selftest_fail_flag), 32'h0000_0001, "held");
		apb(1'b1, `SSDT_OFF_ERR, 32'h0000_0001);
		apb(1'b0, `SSDT_OFF_ERR, 32'h0000_0000);
		chk(rd & 32'h0000_0001, 32'h0000_0000, "cleared");
		scan_resp <= 31'h0000_0000;
		$display("test logic fail done");
	endtask

	task automatic t_xdcr_fail;
		ang_off <= 12'h100;
		apb(1'b1, `SSDT_OFF_CTRL, {24'h00_0000, `SSDT_CMD_XDCR});
		repeat (3) @(posedge sys_clk);
		chk(32'(xdcr_test_mode), 32'h0000_0001, "test config");
		wait_done;
		apb(1'b0, `SSDT_OFF_ERR, 32'h0000_0000);
		chk(rd & 32'h0000_0001, 32'h0000_0001, "angle fail");
		apb(1'b1, `SSDT_OFF_ERR, 32'h0000_0001);
		ang_off <= 12'h000;
		$display("test transducer fail done");
	endtask

	task automatic t_disable;
		do_reset(24'h00_2000);
		apb(1'b1, `SSDT_OFF_CTRL, {24'h00_0000, `SSDT_CMD_BOTH});
		repeat (3) @(posedge sys_clk);
		apb(1'b0, `SSDT_OFF_STAT, 32'h0000_0000);
		chk(rd & 32'h0000_0006, 32'h0000_0000, "refused");
		$display("test disable done");
	endtask

	task automatic t_wdg;
		repeat (2100) @(posedge sys_clk);
		chk(32'(wdg_fail), 32'h0000_0000, "osc healthy");
		ref_run <= 1'b0;
		repeat (600) @(posedge sys_clk);
		chk(32'(wdg_fail), 32'h0000_0001, "osc stopped");
		apb(1'b0, `SSDT_OFF_ERR, 32'h0000_0000);
		chk(rd & 32'h0000_0004, 32'h0000_0004, "period fail");
		repeat (3500) @(posedge sys_clk);
		apb(1'b0, `SSDT_OFF_ERR, 32'h0000_0000);
		chk(rd & 32'h0000_0002, 32'h0000_0002, "window fail");
		$display("test watchdog done");
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// cut a hang short
	initial begin
		#100000;
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict;
	end

	initial begin
		do_reset(24'h00_0000);
		t_alive;
		t_powerup;
		t_lbist_fail;
		t_xdcr_fail;
		t_disable;
		t_wdg;
		print_verdict;
	end
endmodule // ssdt_top_tb
